// ---- src/adc_seq_consts.svh ----
// offsets, field positions, reset values and timing counts of the sequencer block
// Notes on behaviour
// - range and single-ended bits pick one of four input spans.
// - single-ended mode routes the input whose index equals the channel address.
// - differential mode pairs even n with n+1, odd n with n-1.
// - coding bit 1 gives straight binary, 0 gives two's complement.
// - both power bits set keeps the converter fully powered.
// - upper power bit clear shuts down after each conversion.
// - after leaving shutdown a 1 us wake interval precedes valid conversion.
// - sequencer enable and mask select both 0 means plain multiplexed operation.
// - direct mode converts the channel of the preceding write.
// - enable 0, mask select 1 makes the next serial write load the mask.
// - loaded mask channels convert in turn, one per chip-select falling edge.
// - any channel set, adjacent or not, is sequenced; only set ones.
// - enable 1, mask select 0 write does not disturb the running sequence.
// - that hold write still updates power, drive, range, coding, single-ended.
// - both bits 1 converts channels 0 up to the address value repeatedly.
// - 13-bit control word fields decode as write, seq, address, power, etc.
// - mask bit 15 is input 0, down to bit 0 for input 15.
// - sequence ascends and wraps until a write other than hold arrives.
// - an all-zero mask selects channel 15.
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
`define OFF_CTRL 12'h000
`define OFF_MASK 12'h004
`define OFF_STATUS 12'h008
`define BIT_WRITE 12
`define BIT_SEQ 11
`define BIT_ADDR_HI 10
`define BIT_ADDR_LO 7
`define BIT_PM_HI 6
`define BIT_PM_LO 5
`define BIT_MASK_SEL 4
`define BIT_DRIVE 3
`define BIT_RANGE 2
`define BIT_CODING 1
`define BIT_SE 0
`define CTRL_RESET 13'h0000
`define MASK_RESET 16'h0000
`define CTRL_EDGES 5'd13
`define FRAME_EDGES 5'd16
`define WAKE_NS 1000
`define CLK_NS 40
`define WAKE_CYCLES 5'((`WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- src/adc_seq_pkg.sv ----
// types shared by the channel sequencer block
package adc_seq_pkg;
    typedef enum logic [1:0] {seq_direct, seq_mask, seq_count} seq_mode_t;

    typedef struct packed {
        logic [3:0] mux_pos;
        logic [3:0] mux_neg;
        logic differential;
        logic range_sel;
        logic coding_sel;
        logic output_drive_select;
    } conv_cfg_t;

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic csn_s1;
        logic csn_s2;
        logic csn_d;
        logic din_s1;
        logic din_s2;
        logic [4:0] bit_cnt;
        logic [15:0] shift;
        logic mask_armed;
        logic mask_frame;
        logic [12:0] ctrl;
        logic [15:0] mask;
        seq_mode_t mode;
        logic [3:0] seq_limit;
        logic restart;
        logic [3:0] cur_ch;
        conv_cfg_t cfg;
        logic power_on;
        logic conv_valid;
        logic [4:0] wake_cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;
endpackage

// ---- src/adc_channel_sequencer.sv ----
// control word decode, channel sequencer and power sequencing with an apb view
//
// Chosen here: the register offsets and the APB interface to the registers.
`include "adc_seq_consts.svh"

module adc_channel_sequencer
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial port pins from the host
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic din,
    // converter steering
    output conv_cfg_t cfg,
    output logic power_on,
    output logic conv_valid
);
    state_t r;
    state_t n;
    logic sclk_fall;
    logic csn_fall;
    logic csn_rise;
    logic wr_ctrl;
    logic [12:0] word;
    logic [3:0] ch;
    logic setup;
    logic access;
    logic drop;

    // next selected channel above cur, wrapping; empty mask falls back to 15
    function automatic logic [3:0] next_in_mask(input logic [15:0] m, input logic [3:0] cur);
        logic [3:0] c;
        logic found;
        next_in_mask = 4'hf;
        found = 1'b0;
        for (int i = 1; i <= 16; i++) begin
            c = 4'(cur + 4'(i));
            if (!found && m[4'hf - c]) begin
                next_in_mask = c;
                found = 1'b1;
            end
        end
    endfunction

    always_comb begin
        n = r;
        wr_ctrl = 1'b0;
        word = `CTRL_RESET;
        ch = r.cur_ch;
        drop = 1'b0;
        // pins pass two flops; edges are found on the second and third stage only
        n.sclk_s1 = sclk;
        n.sclk_s2 = r.sclk_s1;
        n.sclk_d = r.sclk_s2;
        n.csn_s1 = chip_select_n;
        n.csn_s2 = r.csn_s1;
        n.csn_d = r.csn_s2;
        n.din_s1 = din;
        n.din_s2 = r.din_s1;
        sclk_fall = r.sclk_d & ~r.sclk_s2;
        csn_fall = r.csn_d & ~r.csn_s2;
        csn_rise = ~r.csn_d & r.csn_s2;
        setup = psel & ~penable;
        access = psel & penable & r.pready;

        // wake timer: conversions count as valid only after the interval
        if (r.wake_cnt != 5'd0) begin
            n.wake_cnt = r.wake_cnt - 5'd1;
            if (r.wake_cnt == 5'd1) begin
                n.conv_valid = 1'b1;
            end
        end

        if (csn_fall) begin
            // conversion start: sample pending settings and pick the channel
            n.bit_cnt = 5'd0;
            n.mask_frame = r.mask_armed;
            n.mask_armed = 1'b0;
            case (r.mode)
                seq_direct: ch = r.ctrl[`BIT_ADDR_HI:`BIT_ADDR_LO];
                seq_mask: ch = next_in_mask(r.mask, r.restart ? 4'hf : r.cur_ch);
                seq_count: ch = (r.restart || r.cur_ch >= r.seq_limit) ? 4'h0
                    : 4'(r.cur_ch + 4'h1);
                default: ch = r.cur_ch;
            endcase
            n.restart = 1'b0;
            n.cur_ch = ch;
            n.cfg.mux_pos = ch;
            n.cfg.mux_neg = r.ctrl[`BIT_SE] ? ch : {ch[3:1], ~ch[0]};
            n.cfg.differential = ~r.ctrl[`BIT_SE];
            n.cfg.range_sel = r.ctrl[`BIT_RANGE];
            n.cfg.coding_sel = r.ctrl[`BIT_CODING];
            n.cfg.output_drive_select = r.ctrl[`BIT_DRIVE];
            if (!r.power_on) begin
                n.power_on = 1'b1;
                n.conv_valid = 1'b0;
                n.wake_cnt = `WAKE_CYCLES;
            end
        end else if (!r.csn_s2 && sclk_fall && r.bit_cnt != 5'h1f) begin
            n.shift = {r.shift[14:0], r.din_s2};
            n.bit_cnt = r.bit_cnt + 5'd1;
            // a mask frame carries no control word
            if (r.bit_cnt == `CTRL_EDGES - 5'd1 && !r.mask_frame) begin
                word = {r.shift[11:0], r.din_s2};
                wr_ctrl = word[`BIT_WRITE];
            end
            // the drop is applied last, so a same-cycle full power write keeps power
            if (r.bit_cnt == `FRAME_EDGES - 5'd1 && !r.ctrl[`BIT_PM_HI]) begin
                drop = 1'b1;
            end
        end

        // the mask is taken only at the frame's end, and only if all bits came
        if (csn_rise && r.mask_frame) begin
            n.mask_frame = 1'b0;
            if (r.bit_cnt >= `FRAME_EDGES) begin
                n.mask = r.shift;
                n.mode = seq_mask;
                n.restart = 1'b1;
            end
        end

        // apb: setup decodes, one access cycle answers
        n.pready = setup;
        n.pslverr = 1'b0;
        if (setup) begin
            n.prdata = 32'h0;
            case (paddr)
                `OFF_CTRL: n.prdata = {19'h0, r.ctrl};
                `OFF_MASK: n.prdata = {16'h0, r.mask};
                `OFF_STATUS: n.prdata = {22'h0, r.conv_valid, r.power_on, r.mode,
                    r.mask_armed, r.mask_frame, r.cur_ch};
                default: n.pslverr = 1'b1;
            endcase
        end
        if (access && pwrite) begin
            if (paddr == `OFF_CTRL) begin
                // a same-cycle software write overrides a serial one
                word = pwdata[12:0];
                wr_ctrl = pwdata[`BIT_WRITE];
            end else if (paddr == `OFF_MASK) begin
                n.mask = pwdata[15:0];
                n.mode = seq_mask;
                n.restart = 1'b1;
            end
        end

        if (wr_ctrl) begin
            n.ctrl = word;
            case ({word[`BIT_SEQ], word[`BIT_MASK_SEL]})
                2'b00: n.mode = seq_direct;
                2'b01: begin
                    n.mode = seq_direct;
                    n.mask_armed = 1'b1;
                end
                2'b10: n.mode = r.mode;
                default: begin
                    n.mode = seq_count;
                    n.seq_limit = word[`BIT_ADDR_HI:`BIT_ADDR_LO];
                    n.restart = 1'b1;
                end
            endcase
            if (word[`BIT_PM_HI] && word[`BIT_PM_LO] && !r.power_on) begin
                n.power_on = 1'b1;
                n.conv_valid = 1'b0;
                n.wake_cnt = `WAKE_CYCLES;
            end
        end
        // full power mode never drops power, whatever the pins do
        if (drop && !(n.ctrl[`BIT_PM_HI] && n.ctrl[`BIT_PM_LO])) begin
            n.power_on = 1'b0;
            n.conv_valid = 1'b0;
            n.wake_cnt = 5'd0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.csn_s1 <= 1'b1;
            r.csn_s2 <= 1'b1;
            r.csn_d <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign cfg = r.cfg;
    assign power_on = r.power_on;
    assign conv_valid = r.conv_valid;
endmodule

// ---- dv/adc_seq_asserts.sv ----
// concurrent checks on the channel sequencer ports
module adc_seq_asserts
    import adc_seq_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial pin and converter steering
    input wire logic chip_select_n,
    input wire conv_cfg_t cfg,
    input wire logic power_on,
    input wire logic conv_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    chk_apb_answer: assert property (setup_s |=> access_s)
        else $error("apb answer late");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_map: assert property (pready |->
        pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
        else $error("pslverr does not match address");
    chk_err_data: assert property (pslverr |-> prdata == 32'h0)
        else $error("read data not zero on error");
    chk_diff_pair: assert property (cfg.differential |->
        cfg.mux_neg == (cfg.mux_pos ^ 4'h1))
        else $error("differential partner wrong");
    // settings may only move once a frame has begun, never mid conversion
    chk_cfg_frame: assert property ($changed(cfg) |-> !$past(chip_select_n, 2))
        else $error("cfg changed outside conversion start");
    chk_wake_hold: assert property ($rose(power_on) |-> !conv_valid [*8])
        else $error("valid too soon after wake");
    chk_wake_len: assert property ($rose(conv_valid) |-> $past(power_on, 25))
        else $error("wake interval too short");
endmodule

bind adc_channel_sequencer adc_seq_asserts chk_u (.pclk, .presetn, .psel, .penable, .paddr,
    .prdata, .pready, .pslverr, .chip_select_n, .cfg, .power_on, .conv_valid);

// ---- dv/host_port.sv ----
// host serial port model: frames of sixteen bits, msb first
module host_port (
    // clock
    input wire logic pclk,
    // serial pins
    output logic sclk,
    output logic chip_select_n,
    output logic din
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'h1;
        chip_select_n = 1'h1;
        din = 1'h1;
    end
    // each sclk level lasts 4 pclk, since the pin synchronisers need 3
    task automatic frame(input logic [15:0] w);
        chip_select_n <= 1'h0;
        repeat (30) @(posedge pclk); // wait out the wake time first
        for (int i = 15; i >= 0; i--) begin
            din <= w[i];
            repeat (4) @(posedge pclk);
            sclk <= 1'h0;
            repeat (4) @(posedge pclk);
            sclk <= 1'h1;
        end
        repeat (4) @(posedge pclk);
        chip_select_n <= 1'h1;
        din <= ~w[0]; // released line shows no stale bit
        repeat (40) @(posedge pclk);
    endtask
endmodule

// ---- dv/tb_top.sv ----
// testbench for the channel sequencer: apb table, then serial sequences
module tb_top
    import adc_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, sclk, chip_select_n, din, power_on, conv_valid;
    conv_cfg_t cfg;
    int n_fail = 0;
    int n_tests = 0;
    // control word beside channel, differential, range and coding
    logic [19:0] rows [4] = '{{13'h12e7, 7'h2b}, {13'h1360, 7'h34},
        {13'h13e6, 7'h3f}, {13'h17eb, 7'h79}};
    always #20 pclk = ~pclk;
    adc_channel_sequencer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sclk, .chip_select_n, .din, .cfg,
        .power_on, .conv_valid);
    host_port host_u (.pclk, .sclk, .chip_select_n, .din);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            n_fail++;
            give_verdict();
        end
        @(posedge pclk);
    endtask
    // four frames, the third one carrying word w
    task automatic run4(input logic [15:0] e, input logic [15:0] w);
        for (int j = 0; j < 4; j++) begin
            host_u.frame(j == 2 ? w : 16'h0);
            check(cfg.mux_pos, e[4*j+:4]);
        end
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        check({cfg, power_on}, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, 12'h00c, 32'h0);
        check(err, 1'h1);
        foreach (rows[i]) begin
            apb(1'h1, 12'h000, 32'(rows[i][19:7]));
            apb(1'h0, 12'h000, 32'h0);
            check(rd, 32'(rows[i][19:7]));
            host_u.frame(16'h0);
            check({cfg.mux_pos, cfg.differential, cfg.range_sel, cfg.coding_sel},
                rows[i][6:0]);
            check(power_on, 1'h1);
            check(cfg.output_drive_select, rows[i][10]);
            if (rows[i][2]) begin
                check(cfg.mux_neg, rows[i][6:3] ^ 4'h1);
            end
        end
        host_u.frame({13'h14e7, 3'h0});
        host_u.frame(16'h0);
        check(cfg.mux_pos, 4'h9);
        host_u.frame({13'h1070, 3'h0});
        host_u.frame(16'h2104);
        run4(16'h2d72, {13'h1863, 3'h0});
        check({cfg.range_sel, cfg.coding_sel}, 2'h1);
        check(cfg.differential, 1'h0);
        apb(1'h1, 12'h000, 32'h1977);
        run4(16'h0210, 16'h0);
        apb(1'h1, 12'h004, 32'h0);
        host_u.frame(16'h0);
        check(cfg.mux_pos, 4'hf);
        // status: valid, powered, mask mode, nothing armed, channel 15
        apb(1'h0, 12'h008, 32'h0);
        check(rd, 32'h34f);
        check(err, 1'h0);
        apb(1'h1, 12'h000, 32'h1007);
        host_u.frame(16'h0);
        check(power_on, 1'h0);
        check(cfg.mux_pos, 4'h0);
        // wake from shutdown by a full power write: valid only after the whole interval
        apb(1'h1, 12'h000, 32'h1067);
        check({power_on, conv_valid}, 2'h2);
        repeat (23) @(posedge pclk);
        check(conv_valid, 1'h0);
        repeat (2) @(posedge pclk);
        check(conv_valid, 1'h1);
        give_verdict();
    end
endmodule
